/* File: verilog/wdc_watchdog.sv */
/*
 * Windowed watchdog with clock-frequency monitor and open-drain fault pin.
 * Assumes a register master on the system clock, an oscillator pin at ten
 * times the instruction rate, and an external pull-up on the fault pin.
 */
// Contract
// - Service byte: window, fixed key, monitor enable
// - Service before 256 cycles is error
// - Window select picks 8k to 64k limit
// - Watchdog active only while option bit2 zero
// - Reset enables, then max window, monitor on
// - First keyed write fixes window and monitor
// - Later writes must match all fields
// - First write accepted anywhere, even early
// - Hold pin 16-32 cycles after low
// - Services ignored while fault active
// - Slow clock drives pin until recovered
// - Monitor errors if clock never starts
// - Key field reads back as zeros
// - Halt/idle suspend watchdog, not monitor
// - Halt exit resumes or reloads window
// - Idle exit is a hardware service
// - Idle flag every 4096 cycles, kept
`timescale 1ns/1ps
module wdc_watchdog
	import wdc_pkg::*;
#(
	parameter int CM_LIMIT_CYC = CM_LIMIT_CYC_DEF
) (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_n_i, // Sync reset, low active
	input wire logic power_on_n_i, // Power-on reset, low active
	input wire logic [3:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [7:0] rdata_o, // Read data, cycle after strobe
	input wire logic clock_input_pin_i, // Oscillator pin
	input wire logic halt_i, // HALT state
	input wire logic idle_i, // IDLE state
	input wire logic port_g_pin_one_i, // Fault pin level
	output logic port_g_pin_one_o, // Fault pin drive level
	output logic port_g_pin_one_oe_o, // Fault pin enable
	output logic irq_o // Interrupt, high level
);
	wdc_idle_if idle_link();

	logic cki_s1_ff, cki_s2_ff, cki_s3_ff, pin_s1_ff, pin_s2_ff;
	logic [3:0] div_ff, nxt_div;
	logic tick_ff, nxt_tick;
	logic halt_q_ff, idle_q_ff;

	// ------------------------------------------------------------------
	// Pin synchronisers and instruction tick
	// ------------------------------------------------------------------
	always_comb begin
		nxt_div = div_ff;
		nxt_tick = 1'b0;
		if (cki_s2_ff && !cki_s3_ff) begin
			if (div_ff == 4'(CKI_PER_TC - 4'h1)) begin
				nxt_div = 4'h0;
				nxt_tick = 1'b1;
			end else begin
				nxt_div = 4'(div_ff + 4'h1);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		cki_s1_ff <= clock_input_pin_i;
		cki_s2_ff <= cki_s1_ff;
		cki_s3_ff <= cki_s2_ff;
		pin_s1_ff <= port_g_pin_one_i;
		pin_s2_ff <= pin_s1_ff;
		if (!reset_n_i) begin
			div_ff <= 4'h0;
			tick_ff <= 1'b0;
			halt_q_ff <= 1'b0;
			idle_q_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
			halt_q_ff <= halt_i;
			idle_q_ff <= idle_i;
		end
	end

	assign idle_link.tick = tick_ff;

	wdc_idle_timer wdc_idle_timer_inst (
		.clk_sys_i(clk_sys_i),
		.power_on_n_i(power_on_n_i),
		.idle(idle_link)
	);

	// ------------------------------------------------------------------
	// Registers, window counter and fault sequencer
	// ------------------------------------------------------------------
	wdc_fault_state_type state_ff, nxt_state;
	logic [1:0] sel_ff, nxt_sel;
	logic cm_en_ff, nxt_cm_en, cfg_ff, nxt_cfg;
	logic [16:0] cnt_ff, nxt_cnt;
	logic [4:0] hold_ff, nxt_hold;
	logic [7:0] option_ff, nxt_option, ctrl_ff, nxt_ctrl, rdata_ff, nxt_rdata;
	logic [2:0] status_ff, nxt_status, mask_ff, nxt_mask;
	logic oe_ff, nxt_oe, irq_ff, nxt_irq;
	logic [16:0] gap_ff, nxt_gap;
	logic slow_ff, nxt_slow;
	logic [4:0] rec_ff, nxt_rec;
	logic svc_wr, wd_en, low_pwr, cm_drive, bad_svc, wd_err;
	logic [2:0] events;

	always_comb begin
		nxt_state = state_ff;
		nxt_sel = sel_ff;
		nxt_cm_en = cm_en_ff;
		nxt_cfg = cfg_ff;
		nxt_cnt = cnt_ff;
		nxt_hold = hold_ff;
		nxt_option = option_ff;
		nxt_ctrl = ctrl_ff;
		nxt_mask = mask_ff;
		nxt_gap = gap_ff;
		nxt_slow = slow_ff;
		nxt_rec = rec_ff;
		nxt_rdata = 8'h00;
		svc_wr = wr_i && (addr_i == OFS_SERVICE);
		wd_en = !option_ff[OPT_WD_OFF_BIT];
		low_pwr = halt_i || idle_i;
		bad_svc = 1'b0;
		wd_err = 1'b0;

		if (tick_ff) begin
			nxt_gap = 17'h00000;
			nxt_slow = 1'b0;
		end else if (gap_ff >= 17'(CM_LIMIT_CYC)) begin
			nxt_slow = 1'b1;
		end else begin
			nxt_gap = 17'(gap_ff + 17'h00001);
		end
		if (slow_ff) begin
			nxt_rec = FAULT_HOLD_TC;
		end else if (tick_ff && rec_ff != 5'h00) begin
			nxt_rec = 5'(rec_ff - 5'h01);
		end
		cm_drive = wd_en && cm_en_ff && (slow_ff || rec_ff != 5'h00);

		if (wr_i && addr_i == OFS_OPTION) begin
			nxt_option = wdata_i;
		end else if (wr_i && addr_i == OFS_CTRL) begin
			nxt_ctrl = wdata_i;
		end else if (wr_i && addr_i == OFS_MASK) begin
			nxt_mask = wdata_i[2:0];
		end

		case (state_ff)
			ST_ARMED: begin
				if (svc_wr && !cfg_ff) begin
					if (wdata_i[KEY_HI:KEY_LO] == SVC_KEY) begin
						nxt_sel = wdata_i[SEL_HI:SEL_LO];
						nxt_cm_en = wdata_i[CM_BIT];
						nxt_cfg = 1'b1;
						nxt_cnt = 17'h00000;
					end else begin
						bad_svc = 1'b1;
					end
				end else if (svc_wr) begin
					if (wdata_i == {sel_ff, SVC_KEY, cm_en_ff} && cnt_ff >= LOWER_TC) begin
						nxt_cnt = 17'h00000;
					end else begin
						bad_svc = 1'b1;
					end
				end else if (idle_q_ff && !idle_i) begin
					nxt_cnt = 17'h00000;
				end else if (halt_q_ff && !halt_i) begin
					if (!(ctrl_ff[CTRL_RC_OSC_BIT] && !ctrl_ff[CTRL_CLOCK_START_DELAY_SEL_BIT])) begin
						nxt_cnt = 17'h00000;
					end
				end else if (tick_ff && !low_pwr) begin
					if (17'(cnt_ff + 17'h00001) >= wdc_upper(sel_ff)) begin
						wd_err = 1'b1;
					end else begin
						nxt_cnt = 17'(cnt_ff + 17'h00001);
					end
				end
				wd_err = wd_en && (wd_err || bad_svc);
				if (wd_err) begin
					nxt_state = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (!pin_s2_ff) begin
					nxt_state = ST_HOLD;
					nxt_hold = 5'h00;
				end
			end
			ST_HOLD: begin
				if (tick_ff) begin
					nxt_hold = 5'(hold_ff + 5'h01);
					if (hold_ff == 5'(FAULT_HOLD_TC - 5'h01)) begin
						nxt_state = ST_WAIT_HIGH;
					end
				end
			end
			default: begin
				if (pin_s2_ff) begin
					nxt_state = ST_ARMED;
					nxt_cnt = 17'h00000;
				end
			end
		endcase
		if (!wd_en) begin
			nxt_state = ST_ARMED;
		end

		nxt_oe = cm_drive || (state_ff == ST_DRIVE) || (state_ff == ST_HOLD);
		events = 3'h0;
		events[ST_WD_BIT] = wd_err;
		events[ST_CM_BIT] = cm_drive && !oe_ff;
		events[ST_IDLE_BIT] = idle_link.flag_set;
		nxt_status = status_ff;
		if (wr_i && addr_i == OFS_STATUS) begin
			nxt_status = status_ff & ~wdata_i[2:0];
		end
		nxt_status = nxt_status | events;
		nxt_irq = |(nxt_status & nxt_mask);

		if (rd_i) begin
			if (addr_i == OFS_SERVICE) begin
				nxt_rdata = {sel_ff, 5'h00, cm_en_ff};
			end else if (addr_i == OFS_OPTION) begin
				nxt_rdata = option_ff;
			end else if (addr_i == OFS_CTRL) begin
				nxt_rdata = ctrl_ff;
			end else if (addr_i == OFS_STATUS) begin
				nxt_rdata = {5'h00, status_ff};
			end else if (addr_i == OFS_MASK) begin
				nxt_rdata = {5'h00, mask_ff};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_ARMED;
			sel_ff <= SEL_RST;
			cm_en_ff <= CM_EN_RST;
			cfg_ff <= 1'b0;
			cnt_ff <= 17'h00000;
			hold_ff <= 5'h00;
			option_ff <= OPTION_RST;
			ctrl_ff <= CTRL_RST;
			status_ff <= STATUS_RST;
			mask_ff <= MASK_RST;
			rdata_ff <= 8'h00;
			oe_ff <= 1'b0;
			irq_ff <= 1'b0;
			gap_ff <= 17'h00000;
			slow_ff <= 1'b0;
			rec_ff <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			sel_ff <= nxt_sel;
			cm_en_ff <= nxt_cm_en;
			cfg_ff <= nxt_cfg;
			cnt_ff <= nxt_cnt;
			hold_ff <= nxt_hold;
			option_ff <= nxt_option;
			ctrl_ff <= nxt_ctrl;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			rdata_ff <= nxt_rdata;
			oe_ff <= nxt_oe;
			irq_ff <= nxt_irq;
			gap_ff <= nxt_gap;
			slow_ff <= nxt_slow;
			rec_ff <= nxt_rec;
		end
	end

	assign rdata_o = rdata_ff;
	assign port_g_pin_one_o = 1'b0;
	assign port_g_pin_one_oe_o = oe_ff;
	assign irq_o = irq_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_hold_done;
		wd_en && state_ff == ST_HOLD && tick_ff && hold_ff == 5'h17;
	endsequence

	a_key_read_zero: assert property (
		rd_i && addr_i == OFS_SERVICE |=> rdata_o[5:1] == 5'h00)
		else $error("key field visible on read");
	a_early_service: assert property (
		state_ff == ST_ARMED && wd_en && cfg_ff && svc_wr && cnt_ff < LOWER_TC
		|=> state_ff == ST_DRIVE ##1 port_g_pin_one_oe_o)
		else $error("early service not flagged");
	a_first_write_ok: assert property (
		state_ff == ST_ARMED && !cfg_ff && svc_wr && wdata_i[5:1] == SVC_KEY
		|=> cfg_ff && cnt_ff == 17'h00000 && state_ff == ST_ARMED)
		else $error("first keyed write rejected");
	a_choice_fixed: assert property (
		cfg_ff |=> $stable(sel_ff) && $stable(cm_en_ff))
		else $error("window choice changed after configuration");
	a_expiry_error: assert property (
		state_ff == ST_ARMED && wd_en && tick_ff && !low_pwr && !svc_wr && !halt_q_ff
		&& !idle_q_ff && cnt_ff == 17'(wdc_upper(sel_ff) - 17'h00001) |=> state_ff == ST_DRIVE)
		else $error("window expiry missed");
	a_fault_hold: assert property (
		s_hold_done |=> state_ff == ST_WAIT_HIGH ##1 (port_g_pin_one_oe_o == $past(cm_drive)))
		else $error("fault hold length wrong");
	a_ignore_fault: assert property (
		state_ff != ST_ARMED && svc_wr |=> $stable(cfg_ff) && $stable(sel_ff))
		else $error("service taken during fault");
	a_halt_freeze: assert property (
		state_ff == ST_ARMED && halt_i && halt_q_ff && !svc_wr |=> $stable(cnt_ff))
		else $error("window advanced during halt");
	a_cm_drive: assert property (
		wd_en && cm_en_ff && slow_ff |=> port_g_pin_one_oe_o [*2])
		else $error("slow clock not driving pin");
	a_irq_level: assert property (
		idle_link.flag_set && mask_ff[ST_IDLE_BIT] |=> status_ff[ST_IDLE_BIT] ##1 irq_o)
		else $error("idle flag lost or not signalled");
endmodule

/* File: verilog/wdc_pkg.sv */
/*
 * Constants, register map and field layout of the windowed watchdog with
 * clock monitor. Assumes a 125 MHz system clock and an 8-bit register port.
 */
package wdc_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_SERVICE = 4'h0;
	localparam logic [3:0] OFS_OPTION = 4'h1;
	localparam logic [3:0] OFS_CTRL = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam logic [3:0] OFS_MASK = 4'h4;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 6;
	localparam int KEY_HI = 5;
	localparam int KEY_LO = 1;
	localparam int CM_BIT = 0;
	localparam int OPT_WD_OFF_BIT = 2;
	localparam int CTRL_CLOCK_START_DELAY_SEL_BIT = 0;
	localparam int CTRL_RC_OSC_BIT = 1;
	localparam int ST_WD_BIT = 0;
	localparam int ST_CM_BIT = 1;
	localparam int ST_IDLE_BIT = 2;
	localparam logic [4:0] SVC_KEY = 5'h0C;
	localparam logic [1:0] SEL_RST = 2'h3;
	localparam logic CM_EN_RST = 1'b1;
	localparam logic [7:0] OPTION_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] STATUS_RST = 3'h0;
	localparam logic [2:0] MASK_RST = 3'h0;

	// ------------------------------------------------------------------
	// Timing, in instruction cycles unless named otherwise
	// ------------------------------------------------------------------
	localparam logic [16:0] LOWER_TC = 17'h00100;
	localparam logic [16:0] UPPER_8K_TC = 17'h02000;
	localparam logic [16:0] UPPER_16K_TC = 17'h04000;
	localparam logic [16:0] UPPER_32K_TC = 17'h08000;
	localparam logic [16:0] UPPER_64K_TC = 17'h10000;
	localparam logic [4:0] FAULT_HOLD_TC = 5'h18;
	localparam logic [3:0] CKI_PER_TC = 4'hA;
	localparam logic [11:0] IDLE_WRAP = 12'hFFF;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CM_LIMIT_NS = 1000000;
	localparam int CM_LIMIT_CYC_DEF = CM_LIMIT_NS / CLK_PERIOD_NS;

	typedef enum {
		ST_ARMED,
		ST_DRIVE,
		ST_HOLD,
		ST_WAIT_HIGH
	} wdc_fault_state_type;

	function automatic logic [16:0] wdc_upper(input logic [1:0] sel);
		case (sel)
			2'h0: wdc_upper = UPPER_8K_TC;
			2'h1: wdc_upper = UPPER_16K_TC;
			2'h2: wdc_upper = UPPER_32K_TC;
			default: wdc_upper = UPPER_64K_TC;
		endcase
	endfunction

endpackage

/* File: verilog/wdc_idle_if.sv */
/*
 * Link between the watchdog core and its idle timer.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface wdc_idle_if;
	logic tick;
	logic flag_set;
	modport core (output tick, input flag_set);
	modport tmr (input tick, output flag_set);
endinterface

/* File: verilog/wdc_idle_timer.sv */
/*
 * Free-running idle timer of 12 bits, advanced on each instruction cycle.
 * Assumes power_on_n_i is a synchronous power-on reset distinct from the
 * external reset, which leaves the count untouched.
 */
`timescale 1ns/1ps
module wdc_idle_timer
	import wdc_pkg::*;
(
	input wire logic clk_sys_i, // System clock
	input wire logic power_on_n_i, // Power-on reset, low active
	wdc_idle_if.tmr idle // Tick in, flag pulse out
);
	logic [11:0] count_ff;
	logic [11:0] nxt_count;
	logic flag_set_ff;
	logic nxt_flag_set;

	always_comb begin
		nxt_count = count_ff;
		nxt_flag_set = 1'b0;
		if (idle.tick) begin
			nxt_count = 12'(count_ff + 12'h001);
			nxt_flag_set = (count_ff == IDLE_WRAP);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!power_on_n_i) begin
			count_ff <= 12'h000;
			flag_set_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			flag_set_ff <= nxt_flag_set;
		end
	end

	assign idle.flag_set = flag_set_ff;
endmodule

/* File: dv/wdc_pin_model.sv */
/*
 * Fault pin partner: external reset logic holding a weak pull-up.
 * Assumes the block pulls the pin only through its output enable.
 */
`timescale 1ns/1ps
module wdc_pin_model (
	input wire logic pin_drv_i, // Drive level from block
	input wire logic pin_oe_i, // Drive enable from block
	output logic pin_o // Resolved pin level
);
	assign pin_o = pin_oe_i ? pin_drv_i : 1'b1;
endmodule

/* File: dv/windowed_watchdog_clock_monitor_test.sv */
/*
 * Self-checking bench of the watchdog with clock monitor.
 * Assumes the oscillator pin may toggle every system cycle.
 */
`timescale 1ns/1ps
module windowed_watchdog_clock_monitor_test
	import wdc_pkg::*;
();
	localparam int TICK = 20;
	localparam int CM_LIM = 200;
	localparam logic [7:0] SVC = {2'h0, SVC_KEY, 1'b1};
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic power_on_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic clock_input_pin = 1'b0;
	logic cki_run = 1'b0;
	logic halt_i = 1'b0;
	logic idle_i = 1'b0;
	logic [7:0] rdata_o;
	logic pin;
	logic pin_drv;
	logic pin_oe;
	logic irq_o;
	logic rd_d = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] bad[4] = '{8'h18, 8'h59, 8'h1B, 8'hD9};
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;

	// ------------------------------------------------------------------
	// Clocks, design and partner
	// ------------------------------------------------------------------
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (cki_run) begin
			clock_input_pin <= ~clock_input_pin;
		end
	end

	wdc_watchdog #(.CM_LIMIT_CYC(CM_LIM)) wdc_watchdog_inst (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.power_on_n_i(power_on_n_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.clock_input_pin_i(clock_input_pin),
		.halt_i(halt_i),
		.idle_i(idle_i),
		.port_g_pin_one_i(pin),
		.port_g_pin_one_o(pin_drv),
		.port_g_pin_one_oe_o(pin_oe),
		.irq_o(irq_o)
	);

	wdc_pin_model wdc_pin_model_inst (
		.pin_drv_i(pin_drv),
		.pin_oe_i(pin_oe),
		.pin_o(pin)
	);

	// ------------------------------------------------------------------
	// Compare, bus and wait tasks
	// ------------------------------------------------------------------
	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge clk_sys_i);
	endtask

	task automatic hold_chk();
		int n;
		n = 0;
		while (pin_oe === 1'b1 && n < 1000) begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp_flag(n >= 16 * TICK - 30 && n <= 32 * TICK, 1'b1);
		repeat (8) @(posedge clk_sys_i);
	endtask

	task automatic fault(input logic exp);
		repeat (30) @(posedge clk_sys_i);
		cmp_flag(pin_oe, exp);
		if (exp) begin
			wr(OFS_SERVICE, 8'($urandom));
			hold_chk();
		end
	endtask

	task automatic irq_wait();
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 30000) begin
			@(posedge clk_sys_i);
			n++;
		end
		repeat (2) @(posedge clk_sys_i);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Result watcher and timeout
	// ------------------------------------------------------------------
	always @(posedge clk_sys_i) begin
		rd_d <= rd_i;
		if (rd_d) begin
			cmp_rd(rdata_o, exp_q.pop_front());
		end
	end

	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 97000) begin
			error_cnt++;
			$display("Error at %0t: run timed out", $time);
			complete_run();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(30));
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		power_on_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(OFS_SERVICE, 8'hC1);
		rd(OFS_STATUS, 8'h00);
		wr(4'hF, 8'($urandom));
		rd(4'hF, 8'h00);
		repeat (CM_LIM + 40) @(posedge clk_sys_i);
		cmp_flag(pin_oe, 1'b1);
		rd(OFS_STATUS, 8'h02);
		cki_run <= 1'b1;
		hold_chk();
		wr(OFS_STATUS, 8'h07);
		$display("Test reset and dead clock done");
		wr(OFS_SERVICE, SVC);
		rd(OFS_SERVICE, 8'h01);
		fault(1'b0);
		ticks(100);
		wr(OFS_MASK, 8'h01);
		wr(OFS_SERVICE, SVC);
		fault(1'b1);
		rd(OFS_STATUS, 8'h01);
		cmp_flag(irq_o, 1'b1);
		wr(OFS_STATUS, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		cmp_flag(irq_o, 1'b0);
		$display("Test early service done");
		ticks(260 + $urandom_range(40));
		wr(OFS_SERVICE, SVC);
		fault(1'b0);
		foreach (bad[i]) begin
			ticks(260 + $urandom_range(20));
			wr(OFS_SERVICE, bad[i]);
			fault(1'b1);
		end
		$display("Test field mismatches done");
		ticks(200);
		idle_i <= 1'b1;
		ticks(2);
		idle_i <= 1'b0;
		ticks(100);
		wr(OFS_SERVICE, SVC);
		fault(1'b1);
		$display("Test idle exit done");
		wr(OFS_CTRL, 8'h02);
		ticks(100);
		halt_i <= 1'b1;
		ticks(300);
		halt_i <= 1'b0;
		ticks(100);
		wr(OFS_SERVICE, SVC);
		fault(1'b1);
		$display("Test halt resume done");
		wr(OFS_CTRL, 8'h00);
		ticks(300);
		halt_i <= 1'b1;
		ticks(20);
		halt_i <= 1'b0;
		ticks(100);
		wr(OFS_SERVICE, SVC);
		fault(1'b1);
		$display("Test halt reload done");
		wr(OFS_OPTION, 8'h04);
		wr(OFS_SERVICE, 8'h00);
		fault(1'b0);
		wr(OFS_OPTION, 8'h00);
		$display("Test watchdog disable done");
		reset_n_i <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd(OFS_SERVICE, 8'hC1);
		rd(OFS_STATUS, 8'h00);
		wr(OFS_MASK, 8'h04);
		irq_wait();
		cmp_flag(irq_o, 1'b1);
		rd(OFS_STATUS, 8'h04);
		wr(OFS_STATUS, 8'h04);
		repeat (2) @(posedge clk_sys_i);
		cmp_flag(irq_o, 1'b0);
		$display("Test idle flag after reset done");
		complete_run();
	end
endmodule
